/* pifep_regs.vh */
// Contract
// - flags set on source events regardless of enable or global enable bits
// - flags one: host port, converter, rx full, tx empty, sync1, capcomp1, t2, t1
// - rx full flag read-only, follows receive buffer, clears on buffer read
// - tx empty flag read-only, follows transmit buffer, clears on buffer write
// - small package: host port flag, enable, priority absent and read zero
// - capcomp flags set on capture or compare events; unused in pwm mode
// - timer two match and timer one overflow flags stay set until cleared
// - flags two: clock fail 7, comparator 6, collision one 3, capcomp two 0
// - collision flags set on bus collision, held until software writes zero
// - sync port done flags set on transfer completion, held until cleared
// - flags three: sync two done at 7, collision two at 6, rest zero
// - enable registers mirror flag layout, read/write, reset zero
// - without priority, enabled requests forward only with peripheral group enable
// - priority registers mirror flag layout, one high zero low, reset one
// - priority bits ignored unless priority feature enable is set
// - with priority, request goes high or low per its priority bit and global enable; code gates only high with global enable, low with group enable
// - compatibility: group enable gates peripherals, global enable gates all
`ifndef PIFEP_REGS_VH
`define PIFEP_REGS_VH
`define PIFEP_OFF_FLAGS1 12'h000
`define PIFEP_OFF_FLAGS2 12'h004
`define PIFEP_OFF_FLAGS3 12'h008
`define PIFEP_OFF_EN1 12'h00C
`define PIFEP_OFF_EN2 12'h010
`define PIFEP_OFF_EN3 12'h014
`define PIFEP_OFF_PRI1 12'h018
`define PIFEP_OFF_PRI2 12'h01C
`define PIFEP_OFF_CORE 12'h020
`define PIFEP_MASK1_FULL 8'hFF
`define PIFEP_MASK1_SMALL 8'h7F
`define PIFEP_MASK2 8'hC9
`define PIFEP_MASK3 8'hC0
`define PIFEP_RO1 8'h30
`define PIFEP_FLAG_RST 8'h00
`define PIFEP_EN_RST 8'h00
`define PIFEP_PRI_RST 8'hFF
`define PIFEP_CORE_RST 8'h00
`define PIFEP_CORE_GIE 7
`define PIFEP_CORE_PERIPHERAL_GROUP_ENABLE 6
`define PIFEP_CORE_PRIORITY_FEATURE_ENABLE 0
`endif

/* pifep_irq.v */
// Local design decisions: the APB register port and the register addresses.
`include "pifep_regs.vh"
module pifep_irq #(
  parameter SMALL_PACKAGE = 0
) (
  input wire clk_sys_i,
  input wire reset_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output wire pready_o,
  output wire pslverr_o,
  input wire host_port_access_i,
  input wire converter_done_i,
  input wire rx_buffer_full_i,
  input wire tx_buffer_empty_i,
  input wire sync_port_one_done_i,
  input wire capcomp_one_event_i,
  input wire timer_two_match_i,
  input wire timer_one_overflow_i,
  input wire clock_fail_i,
  input wire comparator_change_i,
  input wire collision_one_i,
  input wire capcomp_two_event_i,
  input wire sync_port_two_done_i,
  input wire collision_two_i,
  output reg irq_high_o,
  output reg irq_low_o,
  output wire [7:0] flags_one_o,
  output wire [7:0] flags_two_o,
  output wire [7:0] flags_three_o
);
  // implemented-bit mask of flags one; host port bit absent on small package
  localparam [7:0] MASK1 = SMALL_PACKAGE ? `PIFEP_MASK1_SMALL : `PIFEP_MASK1_FULL;

  reg [7:0] flags1_q;
  reg [7:0] flags2_q;
  reg [7:0] flags3_q;
  reg [7:0] en1_q;
  reg [7:0] en2_q;
  reg [7:0] en3_q;
  reg [7:0] pri1_q;
  reg [7:0] pri2_q;
  reg [7:0] pri3_q;
  reg [7:0] core_q;
  reg [13:0] ev_sync1_q;
  reg [13:0] ev_sync2_q;
  reg [13:0] ev_prev_q;
  wire [13:0] ev_raw;
  wire [13:0] ev_rise;
  wire wr_acc;
  wire [7:0] wdat;
  wire [7:0] ev1;
  wire [7:0] ev2;
  wire [7:0] ev3;
  wire [7:0] lvl1;
  wire [7:0] act1;
  wire [7:0] act2;
  wire [7:0] act3;
  wire global_irq_enable;
  wire peripheral_group_enable;
  wire priority_feature_enable;
  wire any_hi;
  wire any_lo;
  wire any_all;
  reg addr_hit;
  reg [7:0] rd_byte;
  // next-state values of every bus-written register, the requests and the read data
  reg [7:0] flags1_d;
  reg [7:0] flags2_d;
  reg [7:0] flags3_d;
  reg [7:0] en1_d;
  reg [7:0] en2_d;
  reg [7:0] en3_d;
  reg [7:0] pri1_d;
  reg [7:0] pri2_d;
  reg [7:0] core_d;
  reg irq_high_d;
  reg irq_low_d;
  reg [31:0] prdata_d;

  // next flag value: write may clear or set, event set wins over a clear in the same cycle
  function [7:0] flag_next;
    input [7:0] cur;
    input [7:0] ev;
    input [7:0] mask;
    input wr;
    input [7:0] wd;
    begin
      flag_next = ((wr ? wd : cur) | ev) & mask;
    end
  endfunction

  assign ev_raw = {host_port_access_i, converter_done_i, rx_buffer_full_i, tx_buffer_empty_i,
                   sync_port_one_done_i, capcomp_one_event_i, timer_two_match_i, timer_one_overflow_i,
                   clock_fail_i, comparator_change_i, collision_one_i, capcomp_two_event_i,
                   sync_port_two_done_i, collision_two_i};

  // sources may come from other clock domains, so every input is synchronised
  always @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      ev_sync1_q <= 14'h0000;
      ev_sync2_q <= 14'h0000;
      ev_prev_q <= 14'h0000;
    end
    else
    begin
      ev_sync1_q <= ev_raw;
      ev_sync2_q <= ev_sync1_q;
      ev_prev_q <= ev_sync2_q;
    end
  end

  // edge detection turns a held source level into one set event
  assign ev_rise = ev_sync2_q & ~ev_prev_q;
  assign ev1 = {ev_rise[13:12], 2'b00, ev_rise[9:6]};
  assign ev2 = {ev_rise[5], ev_rise[4], 2'b00, ev_rise[3], 2'b00, ev_rise[2]};
  assign ev3 = {ev_rise[1], ev_rise[0], 6'h00};
  // receive full and transmit empty follow the buffer state, not writable
  assign lvl1 = {2'b00, ev_sync2_q[11], ev_sync2_q[10], 4'h0};

  assign wr_acc = psel_i & penable_i & pwrite_i;
  assign wdat = pwdata_i[7:0];
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i & penable_i & ~addr_hit;

  // write strobe for one register offset
  function wr_hit;
    input wr;
    input [11:0] addr;
    input [11:0] off;
    begin
      wr_hit = wr && (addr == off);
    end
  endfunction

  // flags set whatever the enables say; read-only buffer bits are forced from the levels
  always @*
  begin
    flags1_d = flag_next(flags1_q, ev1, MASK1 & ~`PIFEP_RO1, wr_hit(wr_acc, paddr_i, `PIFEP_OFF_FLAGS1), wdat);
    flags1_d = flags1_d | (lvl1 & MASK1);
  end

  // unimplemented bits of flags two are masked so they always read zero
  always @*
  begin
    flags2_d = flag_next(flags2_q, ev2, `PIFEP_MASK2,
                         wr_hit(wr_acc, paddr_i, `PIFEP_OFF_FLAGS2), wdat);
  end

  // only the two top bits of flags three exist
  always @*
  begin
    flags3_d = flag_next(flags3_q, ev3, `PIFEP_MASK3,
                         wr_hit(wr_acc, paddr_i, `PIFEP_OFF_FLAGS3), wdat);
  end

  // enables mirror the flag layout; absent bits never store
  always @*
  begin
    en1_d = en1_q;
    if (wr_hit(wr_acc, paddr_i, `PIFEP_OFF_EN1))
    begin
      en1_d = wdat & MASK1;
    end
  end

  always @*
  begin
    en2_d = en2_q;
    if (wr_hit(wr_acc, paddr_i, `PIFEP_OFF_EN2))
    begin
      en2_d = wdat & `PIFEP_MASK2;
    end
  end

  always @*
  begin
    en3_d = en3_q;
    if (wr_hit(wr_acc, paddr_i, `PIFEP_OFF_EN3))
    begin
      en3_d = wdat & `PIFEP_MASK3;
    end
  end

  // priority bits reset high and only matter with the priority feature on
  always @*
  begin
    pri1_d = pri1_q;
    if (wr_hit(wr_acc, paddr_i, `PIFEP_OFF_PRI1))
    begin
      pri1_d = wdat & MASK1;
    end
  end

  always @*
  begin
    pri2_d = pri2_q;
    if (wr_hit(wr_acc, paddr_i, `PIFEP_OFF_PRI2))
    begin
      pri2_d = wdat & `PIFEP_MASK2;
    end
  end

  // only global, group and priority-feature bits are kept
  always @*
  begin
    core_d = core_q;
    if (wr_hit(wr_acc, paddr_i, `PIFEP_OFF_CORE))
    begin
      core_d = wdat & 8'hC1;
    end
  end

  // all registers share one synchronous reset
  always @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      flags1_q <= `PIFEP_FLAG_RST;
      flags2_q <= `PIFEP_FLAG_RST;
      flags3_q <= `PIFEP_FLAG_RST;
      en1_q <= `PIFEP_EN_RST;
      en2_q <= `PIFEP_EN_RST;
      en3_q <= `PIFEP_EN_RST;
      pri1_q <= `PIFEP_PRI_RST & MASK1;
      pri2_q <= `PIFEP_PRI_RST & `PIFEP_MASK2;
      pri3_q <= `PIFEP_PRI_RST & `PIFEP_MASK3;
      core_q <= `PIFEP_CORE_RST;
    end
    else
    begin
      flags1_q <= flags1_d;
      flags2_q <= flags2_d;
      flags3_q <= flags3_d;
      en1_q <= en1_d;
      en2_q <= en2_d;
      en3_q <= en3_d;
      pri1_q <= pri1_d;
      pri2_q <= pri2_d;
      pri3_q <= pri3_q;
      core_q <= core_d;
    end
  end

  assign global_irq_enable = core_q[`PIFEP_CORE_GIE];
  assign peripheral_group_enable = core_q[`PIFEP_CORE_PERIPHERAL_GROUP_ENABLE];
  assign priority_feature_enable = core_q[`PIFEP_CORE_PRIORITY_FEATURE_ENABLE];
  assign act1 = flags1_q & en1_q;
  assign act2 = flags2_q & en2_q;
  assign act3 = flags3_q & en3_q;
  assign any_all = |{act1, act2, act3};
  // the third priority register has no layout here, so its bits stay high priority
  assign any_hi = |{act1 & pri1_q, act2 & pri2_q, act3 & pri3_q};
  assign any_lo = |{act1 & ~pri1_q, act2 & ~pri2_q, act3 & ~pri3_q};

  always @*
  begin
    irq_high_d = 1'b0;
    irq_low_d = 1'b0;
    if (priority_feature_enable)
    begin
      // global enable then gates high, group enable gates low
      irq_high_d = any_hi & global_irq_enable;
      irq_low_d = any_lo & peripheral_group_enable;
    end
    else
    begin
      // compatibility: everything goes to the single high vector
      irq_high_d = any_all & peripheral_group_enable & global_irq_enable;
    end
  end

  // registered requests keep glitches off the core side
  always @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      irq_high_o <= 1'b0;
      irq_low_o <= 1'b0;
    end
    else
    begin
      irq_high_o <= irq_high_d;
      irq_low_o <= irq_low_d;
    end
  end

  always @*
  begin
    addr_hit = 1'b1;
    rd_byte = 8'h00;
    case (paddr_i)
      `PIFEP_OFF_FLAGS1:
        rd_byte = flags1_q;
      `PIFEP_OFF_FLAGS2:
        rd_byte = flags2_q;
      `PIFEP_OFF_FLAGS3:
        rd_byte = flags3_q;
      `PIFEP_OFF_EN1:
        rd_byte = en1_q;
      `PIFEP_OFF_EN2:
        rd_byte = en2_q;
      `PIFEP_OFF_EN3:
        rd_byte = en3_q;
      `PIFEP_OFF_PRI1:
        rd_byte = pri1_q;
      `PIFEP_OFF_PRI2:
        rd_byte = pri2_q;
      `PIFEP_OFF_CORE:
        rd_byte = core_q;
      default: addr_hit = 1'b0;
    endcase
  end

  // read data is captured in the setup cycle and holds until the next read
  always @*
  begin
    prdata_d = prdata_o;
    if (psel_i && !penable_i && !pwrite_i)
    begin
      prdata_d = {24'h000000, rd_byte};
    end
  end

  always @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      prdata_o <= 32'h00000000;
    end
    else
    begin
      prdata_o <= prdata_d;
    end
  end

  assign flags_one_o = flags1_q;
  assign flags_two_o = flags2_q;
  assign flags_three_o = flags3_q;
endmodule // pifep_irq

/* pifep_asserts.sv */
`include "pifep_regs.vh"
module pifep_asserts (
  input wire clk_sys_i,
  input wire reset_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire rx_buffer_full_i,
  input wire timer_one_overflow_i,
  input wire irq_high_o,
  input wire irq_low_o,
  input wire [7:0] flags_one_o,
  input wire [7:0] flags_two_o,
  input wire [7:0] flags_three_o
);
  logic [7:0] core_q;
  wire wr = psel_i && penable_i && pwrite_i;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  // gating bits are not on the ports, so they are shadowed from the bus
  always @(posedge clk_sys_i) core_q <= reset_i ? 8'h00 : (wr && paddr_i == `PIFEP_OFF_CORE) ? pwdata_i[7:0] : core_q;
  sequence s_run; !$past(reset_i) && !$past(reset_i, 2) && !$past(reset_i, 3); endsequence
  property p_spare_two; flags_two_o[5:4] == 2'h0 && flags_two_o[2:1] == 2'h0; endproperty
  a_spare_two: assert property (p_spare_two) else $error("flags two spare set");
  property p_spare_three; flags_three_o[5:0] == 6'h00; endproperty
  a_spare_three: assert property (p_spare_three) else $error("flags three spare set");
  property p_rx; s_run |-> flags_one_o[5] == $past(rx_buffer_full_i, 3); endproperty
  a_rx: assert property (p_rx) else $error("rx flag lag");
  property p_set; $rose(timer_one_overflow_i) |-> ##3 flags_one_o[0]; endproperty
  a_set: assert property (p_set) else $error("timer flag not set");
  property p_hold; flags_one_o[0] && !(wr && paddr_i == `PIFEP_OFF_FLAGS1) |=> flags_one_o[0]; endproperty
  a_hold: assert property (p_hold) else $error("timer flag lost");
  property p_gie; !$past(core_q[7]) |-> !irq_high_o; endproperty
  a_gie: assert property (p_gie) else $error("high without global");
  property p_nopri; !$past(core_q[0]) |-> !irq_low_o; endproperty
  a_nopri: assert property (p_nopri) else $error("low without priority");
  property p_cause; $past({flags_three_o, flags_two_o, flags_one_o}) == 24'h0 |-> !irq_high_o && !irq_low_o; endproperty
  a_cause: assert property (p_cause) else $error("request without flag");
  c_high: cover property (irq_high_o);
  c_low: cover property (irq_low_o);
  c_set: cover property ($rose(timer_one_overflow_i));
endmodule // pifep_asserts
bind pifep_irq pifep_asserts u_asserts (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
  .rx_buffer_full_i(rx_buffer_full_i), .timer_one_overflow_i(timer_one_overflow_i), .irq_high_o(irq_high_o),
  .irq_low_o(irq_low_o), .flags_one_o(flags_one_o), .flags_two_o(flags_two_o), .flags_three_o(flags_three_o));

/* pifep_periph.sv */
module pifep_periph (
  input wire clk_sys_i,
  input wire [23:0] req_i,
  output logic [23:0] ev_o = 24'h0
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [23:0] last_q = 24'h0;
  // a one-cycle request is stretched so the input synchroniser cannot miss it
  always @(posedge clk_sys_i)
  begin
    last_q <= req_i;
    ev_o <= req_i | last_q;
  end
endmodule // pifep_periph

/* test_peripheral_irq_flag_enable_priority.sv */
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin err_count++; $display("mismatch %s exp %h got %h", n, e, a); end end
module test_peripheral_irq_flag_enable_priority;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, sel = 0, ena = 0, wrt = 0, rdy, slv, hi, lo, err_seen;
  logic [11:0] adr = 12'h000;
  logic [31:0] wd = 32'h0, prd, rd, v, seed = 32'h000038A8;
  logic [23:0] req = 24'h0, ev;
  logic [7:0] f1, f2, f3, f1_s;
  logic [31:0] prd_s;
  logic [7:0] rst_tab [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hC9, 8'h00, 8'h00};
  logic [7:0] msk [8] = '{8'hCF, 8'hC9, 8'hC0, 8'hFF, 8'hC9, 8'hC0, 8'hFF, 8'hC9};
  logic [17:0] irq_tab [6] = '{{8'hC0, 8'hFE, 2'b10}, {8'h80, 8'hFF, 2'b00}, {8'hC1, 8'hFE, 2'b01},
    {8'h81, 8'hFE, 2'b00}, {8'h41, 8'hFF, 2'b00}, {8'hC1, 8'hFF, 2'b10}};
  int err_count = 0, checks_done = 0;
  pifep_periph u_periph (.clk_sys_i(clk), .req_i(req), .ev_o(ev));
  pifep_irq #(.SMALL_PACKAGE(0)) dut (.clk_sys_i(clk), .reset_i(rst), .psel_i(sel), .penable_i(ena), .pwrite_i(wrt),
    .paddr_i(adr), .pwdata_i(wd), .prdata_o(prd), .pready_o(rdy), .pslverr_o(slv), .host_port_access_i(ev[7]),
    .converter_done_i(ev[6]), .rx_buffer_full_i(ev[5]), .tx_buffer_empty_i(ev[4]), .sync_port_one_done_i(ev[3]),
    .capcomp_one_event_i(ev[2]), .timer_two_match_i(ev[1]), .timer_one_overflow_i(ev[0]), .clock_fail_i(ev[15]),
    .comparator_change_i(ev[14]), .collision_one_i(ev[11]), .capcomp_two_event_i(ev[8]),
    .sync_port_two_done_i(ev[23]), .collision_two_i(ev[22]), .irq_high_o(hi), .irq_low_o(lo),
    .flags_one_o(f1), .flags_two_o(f2), .flags_three_o(f3));
  pifep_irq #(.SMALL_PACKAGE(1)) dut_small (.clk_sys_i(clk), .reset_i(rst), .psel_i(sel), .penable_i(ena),
    .pwrite_i(wrt), .paddr_i(adr), .pwdata_i(wd), .prdata_o(prd_s), .pready_o(), .pslverr_o(),
    .host_port_access_i(ev[7]), .converter_done_i(ev[6]), .rx_buffer_full_i(ev[5]), .tx_buffer_empty_i(ev[4]),
    .sync_port_one_done_i(ev[3]), .capcomp_one_event_i(ev[2]), .timer_two_match_i(ev[1]),
    .timer_one_overflow_i(ev[0]), .clock_fail_i(ev[15]), .comparator_change_i(ev[14]), .collision_one_i(ev[11]),
    .capcomp_two_event_i(ev[8]), .sync_port_two_done_i(ev[23]), .collision_two_i(ev[22]), .irq_high_o(),
    .irq_low_o(), .flags_one_o(f1_s), .flags_two_o(), .flags_three_o());
  function logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    {sel, ena, wrt, adr, wd} <= {2'b10, w, a, d};
    @(posedge clk);
    ena <= 1'b1;
    do @(posedge clk); while (rdy !== 1'b1);
    rd = prd;
    err_seen = slv;
    {sel, ena} <= 2'b00;
  endtask
  task chk_rd(input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 32'h0);
    `CHK("prdata", {24'h0, e}, rd)
    `CHK("pslverr", a > 12'h020, err_seen)
  endtask
  task pulse(input logic [23:0] m);
    req <= m;
    @(posedge clk);
    req <= 24'h0;
    repeat (8) @(posedge clk);
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial forever #4 clk = ~clk;
  initial
  begin
    repeat (20000) @(posedge clk);
    err_count++;
    summarize();
  end
  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 10; i++) chk_rd(12'(i * 4), rst_tab[i]);
    chk_rd(12'h018, 8'hFF);
    `CHK("small pri one", 32'h0000007F, prd_s)
    $display("test reset values done");
    for (int i = 0; i < 8; i++)
    begin
      v = xs();
      apb(1'b1, 12'(i * 4), v);
      chk_rd(12'(i * 4), v[7:0] & msk[i]);
    end
    for (int i = 0; i < 6; i++) apb(1'b1, 12'(i * 4), 32'h0);
    $display("test register access done");
    for (int i = 0; i < 24; i++)
      if (24'hC0C9CF & (24'h1 << i))
      begin
        pulse(24'h1 << i);
        `CHK("flags", 24'h1 << i, {f3, f2, f1})
        `CHK("small flags one", 8'((24'h1 << i) & 24'h00007F), f1_s)
        for (int k = 0; k < 3; k++) apb(1'b1, 12'(k * 4), 32'h0);
      end
    $display("test event flags done");
    req <= 24'h000030;
    repeat (6) @(posedge clk);
    apb(1'b1, 12'h000, 32'h0);
    chk_rd(12'h000, 8'h30);
    req <= 24'h0;
    repeat (6) @(posedge clk);
    chk_rd(12'h000, 8'h00);
    $display("test buffer flags done");
    apb(1'b1, 12'h00C, 32'h1);
    pulse(24'h000001);
    for (int i = 0; i < 6; i++)
    begin
      apb(1'b1, 12'h018, {24'h0, irq_tab[i][9:2]});
      apb(1'b1, 12'h020, {24'h0, irq_tab[i][17:10]});
      repeat (3) @(posedge clk);
      `CHK("irq", irq_tab[i][1:0], {hi, lo})
    end
    apb(1'b1, 12'h000, 32'h0);
    repeat (3) @(posedge clk);
    `CHK("irq", 2'b00, {hi, lo})
    $display("test request gating done");
    summarize();
  end
endmodule // test_peripheral_irq_flag_enable_priority
